// ==== include/pbmux_defines.svh ====
`ifndef PBMUX_DEFINES_SVH
`define PBMUX_DEFINES_SVH
// Pin positions on the port
`define PBMUX_PIN_SCK 3'd7
`define PBMUX_PIN_MISO 3'd6
`define PBMUX_PIN_MOSI 3'd5
`define PBMUX_PIN_SEL 3'd4
`define PBMUX_PIN_OCA0 3'd3
`define PBMUX_PIN_IRQ2 3'd2
`define PBMUX_PIN_CLKOUT 3'd1
`define PBMUX_PIN_XCLK 3'd0
// Pin-change source numbering base
`define PBMUX_PCSRC_BASE 5'd8
// Reset values of the registered outputs
`define PBMUX_RST_BYTE 8'h00
`endif

// ==== include/pbmux_pkg.sv ====
package pbmux_pkg;
  // Per-pin override bundle, one bit per port pin
  typedef struct packed {
    logic [7:0] dir_override_en;
    logic [7:0] dir_override_val;
    logic [7:0] value_override_en;
    logic [7:0] value_override_val;
    logic [7:0] pullup_override_en;
    logic [7:0] pullup_override_val;
  } pbmux_ovr_s;
  // Pad drive result
  typedef struct packed {
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pullup;
  } pbmux_pad_s;
  // SPI role as seen by the port
  typedef enum logic [1:0] {PBMUX_SPI_OFF, PBMUX_SPI_SLAVE, PBMUX_SPI_MASTER} pbmux_role_e;
endpackage

// ==== design/pbmux_pin.sv ====
`timescale 1ns/1ps
// Generic override cell for one pin
module pbmux_pin (
  input wire logic dir_bit,
  input wire logic out_bit,
  input wire logic pullup_global_disable,
  input wire logic dir_override_en,
  input wire logic dir_override_val,
  input wire logic value_override_en,
  input wire logic value_override_val,
  input wire logic pullup_override_en,
  input wire logic pullup_override_val,
  output logic drive_en,
  output logic drive_val,
  output logic pullup_on
);
  // Direction, value and pull-up selection
  always_comb begin
    drive_en = dir_override_en ? dir_override_val : dir_bit;
    drive_val = value_override_en ? value_override_val : out_bit;
    if (pullup_override_en) begin
      pullup_on = pullup_override_val;
    end else begin
      pullup_on = ~drive_en & out_bit & ~pullup_global_disable;
    end
  end
endmodule // pbmux_pin

// ==== design/pbmux_top.sv ====
`timescale 1ns/1ps
`include "pbmux_defines.svh"
module pbmux_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] dir_bits,
  input wire logic [7:0] out_bits,
  input wire logic pullup_global_disable,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup,
  input wire logic spi_on,
  input wire logic spi_master_select,
  input wire logic spi_sck_drive,
  input wire logic spi_slave_data_out,
  input wire logic spi_master_data_out,
  output logic spi_sck_in,
  output logic spi_master_data_in,
  output logic spi_slave_data_in,
  output logic spi_slave_active,
  input wire logic timer3_compare_b_en,
  input wire logic timer3_compare_b_out,
  input wire logic timer3_compare_a_en,
  input wire logic timer3_compare_a_out,
  input wire logic timer0_compare_b_en,
  input wire logic timer0_compare_b_out,
  input wire logic timer0_compare_a_en,
  input wire logic timer0_compare_a_out,
  output logic timer3_capture_in,
  output logic ext_irq_2_in,
  output logic [7:0] pin_change_src,
  output logic timer1_count_in,
  output logic timer0_count_in,
  input wire logic clock_out_fuse,
  input wire logic divided_clock,
  input wire logic serial_unit_zero_sync,
  input wire logic serial0_clock_drive,
  output logic serial0_ext_clock
);
  import pbmux_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Override computation

  pbmux_role_e role;
  pbmux_ovr_s ovr;
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic [7:0] pu_on;
  logic [7:0] in_q;
  logic [7:0] in_d;
  logic [7:0] pad_out_q;
  logic [7:0] pad_out_d;
  logic [7:0] pad_oe_q;
  logic [7:0] pad_oe_d;
  logic [7:0] pad_pu_q;
  logic [7:0] pad_pu_d;
  logic sel_low;

  // SPI role decode
  always_comb begin
    if (!spi_on) begin
      role = PBMUX_SPI_OFF;
    end else if (spi_master_select) begin
      role = PBMUX_SPI_MASTER;
    end else begin
      role = PBMUX_SPI_SLAVE;
    end
  end

  // Per-pin override drivers; SPI wins over compare outputs
  always_comb begin
    ovr = '0;
    // Forced-input pins keep pull-up via the pull-up override set below
    if (role == PBMUX_SPI_SLAVE) begin
      ovr.dir_override_en[`PBMUX_PIN_SCK] = 1'b1;
      ovr.dir_override_en[`PBMUX_PIN_MOSI] = 1'b1;
      ovr.dir_override_en[`PBMUX_PIN_SEL] = 1'b1;
      ovr.value_override_en[`PBMUX_PIN_MISO] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_MISO] = spi_slave_data_out;
    end else if (role == PBMUX_SPI_MASTER) begin
      ovr.dir_override_en[`PBMUX_PIN_MISO] = 1'b1;
      ovr.value_override_en[`PBMUX_PIN_SCK] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_SCK] = spi_sck_drive;
      ovr.value_override_en[`PBMUX_PIN_MOSI] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_MOSI] = spi_master_data_out;
    end
    // Pull-up on forced inputs follows the output bit
    ovr.pullup_override_en = ovr.dir_override_en & ~ovr.dir_override_val;
    ovr.pullup_override_val = out_bits & {8{~pullup_global_disable}};
    // Compare outputs only where SPI has not claimed the value
    if (!ovr.value_override_en[`PBMUX_PIN_SCK] && timer3_compare_b_en) begin
      ovr.value_override_en[`PBMUX_PIN_SCK] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_SCK] = timer3_compare_b_out;
    end
    if (!ovr.value_override_en[`PBMUX_PIN_MISO] && timer3_compare_a_en) begin
      ovr.value_override_en[`PBMUX_PIN_MISO] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_MISO] = timer3_compare_a_out;
    end
    if (timer0_compare_b_en) begin
      ovr.value_override_en[`PBMUX_PIN_SEL] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_SEL] = timer0_compare_b_out;
    end
    if (timer0_compare_a_en) begin
      ovr.value_override_en[`PBMUX_PIN_OCA0] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_OCA0] = timer0_compare_a_out;
    end
    // Synchronous serial clock: direction bit chooses output or input
    if (serial_unit_zero_sync) begin
      ovr.value_override_en[`PBMUX_PIN_XCLK] = dir_bits[`PBMUX_PIN_XCLK];
      ovr.value_override_val[`PBMUX_PIN_XCLK] = serial0_clock_drive;
    end
    // Divided clock owns pin 1 outright
    if (clock_out_fuse) begin
      ovr.dir_override_en[`PBMUX_PIN_CLKOUT] = 1'b1;
      ovr.dir_override_val[`PBMUX_PIN_CLKOUT] = 1'b1;
      ovr.value_override_en[`PBMUX_PIN_CLKOUT] = 1'b1;
      ovr.value_override_val[`PBMUX_PIN_CLKOUT] = divided_clock;
      ovr.pullup_override_en[`PBMUX_PIN_CLKOUT] = 1'b1;
      ovr.pullup_override_val[`PBMUX_PIN_CLKOUT] = 1'b0;
    end
  end

  // One override cell per pin
  for (genvar i = 0; i < 8; i++) begin : g_pin
    pbmux_pin u_pin (
      .dir_bit(dir_bits[i]),
      .out_bit(out_bits[i]),
      .pullup_global_disable(pullup_global_disable),
      .dir_override_en(ovr.dir_override_en[i]),
      .dir_override_val(ovr.dir_override_val[i]),
      .value_override_en(ovr.value_override_en[i]),
      .value_override_val(ovr.value_override_val[i]),
      .pullup_override_en(ovr.pullup_override_en[i]),
      .pullup_override_val(ovr.pullup_override_val[i]),
      .drive_en(drv_en[i]),
      .drive_val(drv_val[i]),
      .pullup_on(pu_on[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered pad drive and sampled inputs

  // Next pad state; clock pin keeps toggling through reset
  always_comb begin
    pad_oe_d = drv_en;
    pad_out_d = drv_val & drv_en;
    pad_pu_d = pu_on;
    in_d = pad_in;
    if (reset) begin
      pad_oe_d = `PBMUX_RST_BYTE;
      pad_out_d = `PBMUX_RST_BYTE;
      pad_pu_d = `PBMUX_RST_BYTE;
      in_d = `PBMUX_RST_BYTE;
      if (clock_out_fuse) begin
        pad_oe_d[`PBMUX_PIN_CLKOUT] = 1'b1;
        pad_out_d[`PBMUX_PIN_CLKOUT] = divided_clock;
      end
    end
  end

  // Output and input registers
  always_ff @(posedge mclk) begin
    pad_oe_q <= pad_oe_d;
    pad_out_q <= pad_out_d;
    pad_pu_q <= pad_pu_d;
    in_q <= in_d;
  end

  assign pad_oe = pad_oe_q;
  assign pad_out = pad_out_q;
  assign pad_pullup = pad_pu_q;

  ////////////////////////////////////////////////////////////////////////
  // Input routing to peripherals

  assign sel_low = ~in_q[`PBMUX_PIN_SEL];
  // Each peripheral receives the sampled pin level, the serial clock gated by synchronous mode; slave active is the slave role and the inverted select level
  always_comb begin
    spi_sck_in = in_q[`PBMUX_PIN_SCK];
    spi_master_data_in = in_q[`PBMUX_PIN_MISO];
    spi_slave_data_in = in_q[`PBMUX_PIN_MOSI];
    spi_slave_active = (role == PBMUX_SPI_SLAVE) & sel_low;
    timer3_capture_in = in_q[`PBMUX_PIN_MOSI];
    ext_irq_2_in = in_q[`PBMUX_PIN_IRQ2];
    pin_change_src = in_q;
    timer1_count_in = in_q[`PBMUX_PIN_CLKOUT];
    timer0_count_in = in_q[`PBMUX_PIN_XCLK];
    // Clock input only meaningful in synchronous mode
    serial0_ext_clock = serial_unit_zero_sync & in_q[`PBMUX_PIN_XCLK];
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // SPI direction: pads are registered, so each check looks one edge later
  AST_SLAVE_SCK_IN: assert property (@(posedge mclk) disable iff (reset)
    spi_on && !spi_master_select && !clock_out_fuse |=> !pad_oe[7])
    else $error("clock pin driven in slave mode");
  AST_MASTER_SCK_DIR: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select |=> pad_oe[7] == $past(dir_bits[7]))
    else $error("clock pin direction wrong in master mode");
  AST_MASTER_MISO_IN: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select |=> !pad_oe[6])
    else $error("master-in pin driven in master mode");
  AST_SLAVE_MISO_DIR: assert property (@(posedge mclk) disable iff (reset)
    spi_on && !spi_master_select |=> pad_oe[6] == $past(dir_bits[6]))
    else $error("master-in pin direction wrong in slave mode");
  AST_SLAVE_SEL_IN: assert property (@(posedge mclk) disable iff (reset)
    spi_on && !spi_master_select |=> !pad_oe[4] && !pad_oe[5])
    else $error("slave input pins driven");
  AST_MASTER_MOSI_DIR: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select |=> pad_oe[5] == $past(dir_bits[5]))
    else $error("master-out pin direction wrong in master mode");
  AST_MASTER_SEL_DIR: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select |=> pad_oe[4] == $past(dir_bits[4]))
    else $error("select pin direction wrong in master mode");
  // Forced inputs keep the port pull-up; a lost pull-up leaves the line floating
  AST_FORCED_PULLUP: assert property (@(posedge mclk) disable iff (reset)
    spi_on && !spi_master_select |=> pad_pullup[5] ==
      ($past(out_bits[5]) & ~$past(pullup_global_disable)))
    else $error("forced input pull-up wrong");
  AST_MASTER_MISO_PULLUP: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select |=> pad_pullup[6] ==
      ($past(out_bits[6]) & ~$past(pullup_global_disable)))
    else $error("master-in pull-up wrong in master mode");
  AST_SLAVE_SEL_PULLUP: assert property (@(posedge mclk) disable iff (reset)
    spi_on && !spi_master_select |=> pad_pullup[4] ==
      ($past(out_bits[4]) & ~$past(pullup_global_disable)))
    else $error("select pin pull-up wrong in slave mode");
  // SPI data paths and value priority
  AST_SLAVE_ACTIVE: assert property (@(posedge mclk) disable iff (reset)
    spi_slave_active |-> spi_on && !spi_master_select && !in_q[4])
    else $error("slave active without select low");
  AST_SLAVE_MISO_OUT: assert property (@(posedge mclk) disable iff (reset)
    spi_on && !spi_master_select && dir_bits[6] |=> pad_out[6] == $past(spi_slave_data_out))
    else $error("slave data not on master-in pin");
  AST_MASTER_MOSI_OUT: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select && dir_bits[5] |=> pad_out[5] == $past(spi_master_data_out))
    else $error("master data not on master-out pin");
  AST_MASTER_SCK_WINS: assert property (@(posedge mclk) disable iff (reset)
    spi_on && spi_master_select && dir_bits[7] |=> pad_out[7] == $past(spi_sck_drive))
    else $error("clock pin value not from SPI in master mode");
  // Compare outputs, serial clock and divided clock
  AST_COMPARE_DIR: assert property (@(posedge mclk) disable iff (reset)
    !dir_bits[3] |=> !pad_oe[3])
    else $error("compare pin driven with input direction");
  AST_VALUE_OVR: assert property (@(posedge mclk) disable iff (reset)
    timer0_compare_a_en && dir_bits[3] |=> pad_out[3] == $past(timer0_compare_a_out))
    else $error("compare value not on pin 3");
  AST_XCLK_OUT: assert property (@(posedge mclk) disable iff (reset)
    serial_unit_zero_sync && dir_bits[0] |=> pad_oe[0] && pad_out[0] == $past(serial0_clock_drive))
    else $error("serial clock not driven on pin 0");
  AST_XCLK_GATE: assert property (@(posedge mclk) disable iff (reset)
    !serial_unit_zero_sync |-> !serial0_ext_clock)
    else $error("serial clock input outside synchronous mode");
  AST_CLKOUT: assert property (@(posedge mclk)
    clock_out_fuse |=> pad_oe[1] && pad_out[1] == $past(divided_clock))
    else $error("divided clock not on pin 1");
  AST_CLKOUT_RESET: assert property (@(posedge mclk)
    reset && clock_out_fuse |=> pad_oe[1])
    else $error("divided clock pin released during reset");
  AST_FUSE_NO_PULLUP: assert property (@(posedge mclk)
    clock_out_fuse |=> !pad_pullup[1])
    else $error("pull-up on divided clock pin");
  // Pin levels back to peripherals, one cycle after the pad sample
  AST_PCINT: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> pin_change_src == $past(pad_in))
    else $error("pin change source mismatch");
  AST_CAPTURE_ROUTE: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> timer3_capture_in == $past(pad_in[5]))
    else $error("capture input not from pin 5");
  AST_IRQ2_ROUTE: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> ext_irq_2_in == $past(pad_in[2]))
    else $error("external interrupt 2 not from pin 2");
  AST_COUNT_ROUTE: assert property (@(posedge mclk) disable iff (reset)
    1'b1 |=> {timer1_count_in, timer0_count_in} == $past(pad_in[1:0]))
    else $error("timer count inputs not from pins 1 and 0");
  // Main scenarios
  COV_SLAVE: cover property (@(posedge mclk) spi_slave_active);
  COV_MASTER: cover property (@(posedge mclk) spi_on && spi_master_select && pad_oe[7]);
  COV_CLKOUT_RST: cover property (@(posedge mclk) reset && clock_out_fuse);
  COV_XCLK_OUT: cover property (@(posedge mclk) serial_unit_zero_sync && pad_oe[0]);
  COV_COMPARE_PIN: cover property (@(posedge mclk) timer0_compare_a_en && pad_oe[3] && pad_out[3]);
endmodule // pbmux_top

// ==== test/pbmux_pins.sv ====
`timescale 1ns/1ps
// Board side of the eight port pins
module pbmux_pins (
  input wire logic mclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] float_q = 8'h55;
  // Undriven pins without pull-up flip each cycle so a stale sample never looks right
  always @(posedge mclk) begin
    float_q <= ~float_q;
  end
  // Own driver first, then the board (select driven low by a master), then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] :
                  ext_en[i] ? ext_val[i] : (pad_pullup[i] | float_q[i]);
    end
  end
endmodule // pbmux_pins

// ==== test/tb_port_b_alternate_function_mux.sv ====
`timescale 1ns/1ps
module tb_port_b_alternate_function_mux;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] dir_bits = 8'h00, out_bits = 8'h00, pad_in, pad_out, pad_oe, pad_pullup;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00, pin_change_src;
  logic pullup_global_disable = 0, spi_on = 0, spi_master_select = 0, spi_sck_drive = 0;
  logic spi_slave_data_out = 0, spi_master_data_out = 0, timer3_compare_b_en = 0;
  logic timer3_compare_b_out = 0, timer3_compare_a_en = 0, timer3_compare_a_out = 0;
  logic timer0_compare_b_en = 0, timer0_compare_b_out = 0, timer0_compare_a_en = 0;
  logic timer0_compare_a_out = 0, clock_out_fuse = 0, divided_clock = 0;
  logic serial_unit_zero_sync = 0, serial0_clock_drive = 0;
  logic spi_sck_in, spi_master_data_in, spi_slave_data_in, spi_slave_active;
  logic timer3_capture_in, ext_irq_2_in, timer1_count_in, timer0_count_in, serial0_ext_clock;
  int errors = 0;
  int samples_checked = 0;

  // 20 MHz clock
  always #25 mclk = ~mclk;

  pbmux_top i_dut (.mclk, .reset, .dir_bits, .out_bits, .pullup_global_disable, .pad_in,
    .pad_out, .pad_oe, .pad_pullup, .spi_on, .spi_master_select, .spi_sck_drive,
    .spi_slave_data_out, .spi_master_data_out, .spi_sck_in, .spi_master_data_in,
    .spi_slave_data_in, .spi_slave_active, .timer3_compare_b_en, .timer3_compare_b_out,
    .timer3_compare_a_en, .timer3_compare_a_out, .timer0_compare_b_en,
    .timer0_compare_b_out, .timer0_compare_a_en, .timer0_compare_a_out, .timer3_capture_in,
    .ext_irq_2_in, .pin_change_src, .timer1_count_in, .timer0_count_in, .clock_out_fuse,
    .divided_clock, .serial_unit_zero_sync, .serial0_clock_drive, .serial0_ext_clock);

  pbmux_pins i_pins (.mclk, .pad_out, .pad_oe, .pad_pullup, .ext_en, .ext_val, .pad_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Inputs change only at falling edges; three edges cover pad plus input latency
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the roughly 90 cycles the tests need
  initial begin
    #40000;
    errors++;
    tally_and_finish();
  end

  initial begin
    step(20);
    reset = 0;
    // Slave role: clock, master-out and select forced to input, pull-ups kept
    dir_bits = 8'hFF; out_bits = 8'hA0; spi_on = 1; spi_slave_data_out = 1;
    ext_en = 8'hB0; ext_val = 8'h00; step(3);
    check("oe slave", 8'h4F, pad_oe);
    check("pullup slave", 8'hA0, pad_pullup);
    check("slave out", 8'h40, pad_out & 8'h40);
    check("active low sel", 8'h01, {7'h0, spi_slave_active});
    ext_val = 8'h90; step(3);
    check("active high sel", 8'h00, {7'h0, spi_slave_active});
    check("slave ins", 8'h02, {6'h0, spi_sck_in, spi_slave_data_in});
    $display("slave test done");
    // Master role: SPI clock wins over compare, master-in forced to input
    spi_master_select = 1; spi_sck_drive = 1; timer3_compare_b_en = 1;
    timer3_compare_a_en = 1; ext_en = 8'h40; ext_val = 8'h40; step(3);
    check("oe master", 8'hBF, pad_oe);
    check("out master", 8'h80, pad_out & 8'hF0);
    check("master in", 8'h01, {7'h0, spi_master_data_in});
    dir_bits = 8'h00; out_bits = 8'h40; ext_en = 8'hFF; step(3);
    check("oe master dir0", 8'h00, pad_oe);
    check("pullup miso", 8'h40, pad_pullup);
    pullup_global_disable = 1; step(3);
    check("pullup off", 8'h00, pad_pullup);
    $display("master test done");
    // Compares with SPI off reach pins only with direction set
    spi_on = 0; pullup_global_disable = 0; out_bits = 8'h00; ext_en = 8'h27;
    {timer3_compare_b_out, timer3_compare_a_out, timer0_compare_b_out} = 3'h7;
    timer0_compare_a_out = 1; timer0_compare_b_en = 1; timer0_compare_a_en = 1; step(3);
    check("cmp oe dir0", 8'h00, pad_oe & 8'hD8);
    dir_bits = 8'hD8; step(3);
    check("cmp out", 8'hD8, pad_out & 8'hD8);
    out_bits = 8'hD8; {timer3_compare_b_out, timer3_compare_a_out} = 2'h0;
    {timer0_compare_b_out, timer0_compare_a_out} = 2'h0; step(3);
    check("cmp out low", 8'h00, pad_out & 8'hD8);
    $display("compare test done");
    // Pin levels back to peripherals
    dir_bits = 8'h00; ext_en = 8'hFF;
    {timer3_compare_b_en, timer3_compare_a_en, timer0_compare_b_en} = 3'h0;
    timer0_compare_a_en = 0;
    for (int i = 0; i < 8; i++) begin
      ext_val = 8'h01 << i ^ ((i % 2) ? 8'hFF : 8'h00); step(3);
      check("pin change", ext_val, pin_change_src);
      check("periph ins", {4'h0, ext_val[5], ext_val[2], ext_val[1], ext_val[0]},
        {4'h0, timer3_capture_in, ext_irq_2_in, timer1_count_in, timer0_count_in});
    end
    $display("input test done");
    // Serial unit clock on pin 0
    serial_unit_zero_sync = 1; serial0_clock_drive = 1; dir_bits = 8'h01; ext_en = 8'hFE;
    step(3);
    check("xclk out", 8'h01, pad_oe & pad_out & 8'h01);
    dir_bits = 8'h00; ext_en = 8'hFF; ext_val = 8'h01; step(3);
    check("xclk in", 8'h01, {pad_oe[0], serial0_ext_clock});
    serial_unit_zero_sync = 0; step(3);
    check("xclk async", 8'h00, {7'h0, serial0_ext_clock});
    $display("serial clock test done");
    // Divided clock on pin 1, also while held in reset
    clock_out_fuse = 1; ext_en = 8'hFD; divided_clock = 1; out_bits = 8'h00; step(3);
    check("divided_clock_out on", 8'h02, pad_oe & pad_out & 8'h02);
    divided_clock = 0; step(3);
    check("divided_clock_out low", 8'h02, {6'h0, pad_oe[1], pad_out[1]});
    reset = 1; divided_clock = 1; step(3);
    check("divided_clock_out reset", 8'h02, pad_oe & pad_out & 8'h02);
    reset = 0; step(2);
    $display("clock out test done");
    tally_and_finish();
  end
endmodule // tb_port_b_alternate_function_mux
